// *** hw/lhcd_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none

// Function
// - data select: write/read display memory
// - opcode 0000: column pointer low nibble
// - opcode 0001: column pointer high nibble
// - opcode 0110: page pointer low nibble
// - opcode 01110: page pointer bits 6-4
// - 001100RR then byte: program register
// - 82,13,value: front isolation clock
// - 82,14,value: back isolation clock
// - 100001xx: partial display bits
// - 10001xxx: RAM address control
// - C0 then 0000xxxx: mapping bits
module lhcd_decoder
   import lhcd_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic strobe_i,
   input wire logic cd_i,
   input wire logic read_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output logic [7:0] column_pointer_o,
   output logic [6:0] page_pointer_o,
   output logic [31:0] advanced_program_regs_o,
   output logic [3:0] front_isolation_clock_o,
   output logic [3:0] back_isolation_clock_o,
   output logic [9:8] lcd_control_field_hi_o,
   output logic [3:0] lcd_control_field_lo_o,
   output logic [2:0] ram_address_control_o
);

   function automatic logic [11:0] lhcd_addr(input logic [7:0] col, input logic [6:0] page);
      lhcd_addr = 12'(page) * 12'(LHCD_COLS) + 12'(col);
   endfunction

   // a command byte that lands while the sequencer waits in the given state
   function automatic logic lhcd_arg(input logic wr, input lhcd_state_t cur, input lhcd_state_t want);
      lhcd_arg = wr && (cur == want);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] col_r;
   logic [6:0] page_r;
   logic [7:0] prog_r [LHCD_PROG_NUM];
   logic [1:0] prog_sel_r;
   logic [3:0] front_iso_r;
   logic [3:0] back_iso_r;
   logic [1:0] part_r;
   logic [2:0] rac_r;
   logic [3:0] map_r;
   logic [7:0] rdata_r;
   logic rvalid_r;
   lhcd_state_t state_r;
   lhcd_state_t state_nxt;
   // no reset on the array: contents stay undefined until the host writes them
   logic [7:0] mem_r [LHCD_MEM_WORDS];

   ////////////////////////////////////////////////////////////////////////
   // access decode
   wire logic cmd_wr = strobe_i & ~cd_i & ~read_i;
   wire logic dat_wr = strobe_i & cd_i & ~read_i;
   wire logic dat_rd = strobe_i & cd_i & read_i;
   wire logic idle = (state_r == LHCD_ST_IDLE);
   // opcodes are only decoded while idle, so parameter bytes never alias them
   // parameter not decoded
   wire logic op = cmd_wr & idle;
   wire logic op_col_lo = op & (wdata_i[7:4] == LHCD_OP_COL_LO);
   wire logic op_col_hi = op & (wdata_i[7:4] == LHCD_OP_COL_HI);
   wire logic op_page_lo = op & (wdata_i[7:4] == LHCD_OP_PAGE_LO);
   wire logic op_page_hi = op & (wdata_i[7:3] == LHCD_OP_PAGE_HI);
   wire logic op_prog = op & (wdata_i[7:2] == LHCD_OP_PROG);
   wire logic op_iso = op & (wdata_i == LHCD_OP_ISO);
   wire logic op_part = op & (wdata_i[7:2] == LHCD_OP_PART);
   wire logic op_rac = op & (wdata_i[7:3] == LHCD_OP_RAC);
   wire logic op_map = op & (wdata_i == LHCD_OP_MAP);
   // parameter bytes, one wire for each waiting state except LHCD_ST_ISO_SEL
   wire logic arg_prog = lhcd_arg(cmd_wr, state_r, LHCD_ST_PROG_ARG);
   wire logic arg_front = lhcd_arg(cmd_wr, state_r, LHCD_ST_FRONT_ARG);
   wire logic arg_back = lhcd_arg(cmd_wr, state_r, LHCD_ST_BACK_ARG);
   wire logic arg_map = lhcd_arg(cmd_wr, state_r, LHCD_ST_MAP_ARG);
   // a mapping argument with a nonzero upper nibble is dropped, never half applied
   wire logic map_ok = (wdata_i[7:4] == LHCD_MAP_ARG_HI);
   wire logic [11:0] mem_addr = lhcd_addr(col_r, page_r);
   // off-panel pointers must not reach the array, which has no spare words
   wire logic addr_ok = (col_r < 8'(LHCD_COLS)) && (page_r < 7'(LHCD_PAGES));

   ////////////////////////////////////////////////////////////////////////
   // sequencer: a data access in the middle of a sequence abandons it
   // contiguous sequence
   always_comb begin
      state_nxt = state_r;
      if (dat_wr | dat_rd) begin
         state_nxt = LHCD_ST_IDLE;
      end else if (cmd_wr) begin
         case (state_r)
            LHCD_ST_IDLE: begin
               if (op_prog) state_nxt = LHCD_ST_PROG_ARG;
               else if (op_iso) state_nxt = LHCD_ST_ISO_SEL;
               else if (op_map) state_nxt = LHCD_ST_MAP_ARG;
            end
            LHCD_ST_ISO_SEL: begin
               if (wdata_i == LHCD_OP_ISO_FRONT) state_nxt = LHCD_ST_FRONT_ARG;
               else if (wdata_i == LHCD_OP_ISO_BACK) state_nxt = LHCD_ST_BACK_ARG;
               else state_nxt = LHCD_ST_IDLE;
            end
            default: state_nxt = LHCD_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) state_r <= LHCD_ST_IDLE;
      else state_r <= state_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // pointer halves load separately, so one byte never disturbs the other half
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         col_r <= LHCD_COL_RST;
         page_r <= LHCD_PAGE_RST;
      end else begin
         if (op_col_lo) col_r[3:0] <= wdata_i[3:0];
         if (op_col_hi) col_r[7:4] <= wdata_i[3:0];
         if (op_page_lo) page_r[3:0] <= wdata_i[3:0];
         if (op_page_hi) page_r[6:4] <= wdata_i[2:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) prog_sel_r <= LHCD_PROG_SEL_RST;
      else if (op_prog) prog_sel_r <= wdata_i[1:0];
   end

   genvar gi;
   generate
      for (gi = 0; gi < LHCD_PROG_NUM; gi++) begin : g_prog
         always_ff @(posedge sys_clk_i) begin
            if (sys_rst_i) prog_r[gi] <= LHCD_PROG_RST;
            else if (arg_prog && prog_sel_r == 2'(gi)) prog_r[gi] <= wdata_i;
         end
         assign advanced_program_regs_o[gi*8 +: 8] = prog_r[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // front isolation value
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) front_iso_r <= LHCD_FRONT_ISO_RST;
      else if (arg_front) front_iso_r <= wdata_i[3:0];
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) back_iso_r <= LHCD_BACK_ISO_RST;
      else if (arg_back) back_iso_r <= wdata_i[3:0];
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) part_r <= LHCD_PART_RST;
      else if (op_part) part_r <= wdata_i[1:0];
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) rac_r <= LHCD_RAC_RST;
      else if (op_rac) rac_r <= wdata_i[2:0];
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) map_r <= LHCD_MAP_RST;
      else if (arg_map && map_ok) map_r <= wdata_i[3:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // out-of-range addresses are ignored on write and read back as zero;
   // pointers do not auto-advance here, that belongs to the address unit
   // display memory access
   always_ff @(posedge sys_clk_i) begin
      if (dat_wr && addr_ok) mem_r[mem_addr] <= wdata_i;
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rdata_r <= LHCD_RDATA_RST;
         rvalid_r <= 1'h0;
      end else begin
         rvalid_r <= dat_rd;
         if (dat_rd) rdata_r <= addr_ok ? mem_r[mem_addr] : 8'h00;
      end
   end

   assign rdata_o = rdata_r;
   assign rvalid_o = rvalid_r;
   assign column_pointer_o = col_r;
   assign page_pointer_o = page_r;
   assign front_isolation_clock_o = front_iso_r;
   assign back_isolation_clock_o = back_iso_r;
   assign lcd_control_field_hi_o = part_r;
   assign lcd_control_field_lo_o = map_r;
   assign ram_address_control_o = rac_r;

endmodule // lhcd_decoder

`default_nettype wire

// *** hw/lhcd_pkg.sv ***
package lhcd_pkg;
   // reset values
   localparam logic [7:0] LHCD_COL_RST = 8'h00;
   localparam logic [6:0] LHCD_PAGE_RST = 7'h00;
   localparam logic [7:0] LHCD_PROG_RST = 8'h00;
   localparam logic [1:0] LHCD_PROG_SEL_RST = 2'h0;
   localparam logic [3:0] LHCD_FRONT_ISO_RST = 4'h1;
   localparam logic [3:0] LHCD_BACK_ISO_RST = 4'h0;
   localparam logic [1:0] LHCD_PART_RST = 2'h0;
   localparam logic [2:0] LHCD_RAC_RST = 3'h1;
   localparam logic [3:0] LHCD_MAP_RST = 4'h0;
   localparam logic [7:0] LHCD_RDATA_RST = 8'h00;
   // opcodes and opcode prefixes
   localparam logic [3:0] LHCD_OP_COL_LO = 4'h0;
   localparam logic [3:0] LHCD_OP_COL_HI = 4'h1;
   localparam logic [3:0] LHCD_OP_PAGE_LO = 4'h6;
   localparam logic [4:0] LHCD_OP_PAGE_HI = 5'h0E;
   localparam logic [5:0] LHCD_OP_PROG = 6'h0C;
   localparam logic [7:0] LHCD_OP_ISO = 8'h82;
   localparam logic [7:0] LHCD_OP_ISO_FRONT = 8'h13;
   localparam logic [7:0] LHCD_OP_ISO_BACK = 8'h14;
   localparam logic [5:0] LHCD_OP_PART = 6'h21;
   localparam logic [4:0] LHCD_OP_RAC = 5'h11;
   localparam logic [7:0] LHCD_OP_MAP = 8'hC0;
   localparam logic [3:0] LHCD_MAP_ARG_HI = 4'h0;
   // display memory: 160 columns by 20 pages of 8 rows
   localparam int LHCD_COLS = 160;
   localparam int LHCD_PAGES = 20;
   localparam int LHCD_MEM_WORDS = LHCD_COLS * LHCD_PAGES;
   localparam int LHCD_PROG_NUM = 4;

   typedef enum logic [2:0] {
      LHCD_ST_IDLE,
      LHCD_ST_PROG_ARG,
      LHCD_ST_ISO_SEL,
      LHCD_ST_FRONT_ARG,
      LHCD_ST_BACK_ARG,
      LHCD_ST_MAP_ARG
   } lhcd_state_t;
endpackage

// *** sim/lhcd_decoder_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module lhcd_decoder_asserts (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic strobe_i,
   input wire logic cd_i,
   input wire logic read_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] rdata_o,
   input wire logic rvalid_o,
   input wire logic [7:0] column_pointer_o,
   input wire logic [6:0] page_pointer_o,
   input wire logic [3:0] front_isolation_clock_o,
   input wire logic [3:0] back_isolation_clock_o,
   input wire logic [2:0] ram_address_control_o
);
   logic [7:0] w1_r, w2_r, w3_r;
   wire cmd_wr = strobe_i && !cd_i && !read_i;
   wire data_rd = strobe_i && cd_i && read_i;
   // last three bytes seen, to trace a field change back to its opcode bytes
   always_ff @(posedge sys_clk_i) begin
      w1_r <= wdata_i;
      w2_r <= w1_r;
      w3_r <= w2_r;
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   chk_read_answer: assert property (data_rd |=> rvalid_o)
      else $error("data read gave no rvalid");
   chk_no_spurious: assert property (!data_rd |=> !rvalid_o)
      else $error("rvalid without data read");
   chk_rdata_holds: assert property (!rvalid_o |-> $stable(rdata_o))
      else $error("rdata moved without rvalid");
   chk_col_quiet: assert property (!cmd_wr |=> $stable(column_pointer_o))
      else $error("column moved without command");
   chk_col_hi_only: assert property (cmd_wr && wdata_i[7:4] == 4'h1 |=> $stable(column_pointer_o[3:0]))
      else $error("column low nibble disturbed");
   chk_page_lo_only: assert property (cmd_wr && wdata_i[7:4] == 4'h6 |=> $stable(page_pointer_o[6:4]))
      else $error("page high bits disturbed");
   chk_rac_source: assert property (!$stable(ram_address_control_o)
      |-> w1_r[7:3] == 5'h11 && ram_address_control_o == w1_r[2:0])
      else $error("address control changed wrongly");
   chk_front_source: assert property (!$stable(front_isolation_clock_o)
      |-> w3_r == 8'h82 && w2_r == 8'h13 && front_isolation_clock_o == w1_r[3:0])
      else $error("front isolation changed wrongly");
   chk_back_source: assert property (!$stable(back_isolation_clock_o)
      |-> w3_r == 8'h82 && w2_r == 8'h14 && back_isolation_clock_o == w1_r[3:0])
      else $error("back isolation changed wrongly");
endmodule // lhcd_decoder_asserts
bind lhcd_decoder lhcd_decoder_asserts i_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .strobe_i(strobe_i),
   .cd_i(cd_i), .read_i(read_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
   .column_pointer_o(column_pointer_o), .page_pointer_o(page_pointer_o),
   .front_isolation_clock_o(front_isolation_clock_o), .back_isolation_clock_o(back_isolation_clock_o),
   .ram_address_control_o(ram_address_control_o));
`default_nettype wire

// *** sim/lhcd_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module lhcd_host (
   input wire logic sys_clk_i,
   output logic strobe_o,
   output logic cd_o,
   output logic read_o,
   output logic [7:0] wdata_o
);
   initial begin
      strobe_o = 1'b0;
      cd_o = 1'b0;
      read_o = 1'b0;
      wdata_o = 8'h00;
   end
   // one byte per cycle, back to back
   task automatic acc(input logic cd, input logic rd, input logic [7:0] d);
      @(posedge sys_clk_i);
      #5;
      strobe_o = 1'b1;
      cd_o = cd;
      read_o = rd;
      wdata_o = d;
   endtask
   // released bus shows a changed pattern, not the last byte
   task automatic idle();
      @(posedge sys_clk_i);
      #5;
      strobe_o = 1'b0;
      wdata_o = ~wdata_o;
   endtask
endmodule // lhcd_host
`default_nettype wire

// *** sim/lhcd_decoder_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module lhcd_decoder_tb;
   import lhcd_pkg::*;
   logic clk, rst, strobe, cd, rd, rvalid;
   logic [7:0] wd, rdata, col;
   logic [6:0] page;
   logic [31:0] prog;
   logic [3:0] fiso, biso, lclo;
   logic [9:8] lchi;
   logic [2:0] rac;
   int num_errors = 0;
   int tests_run = 0;
   lhcd_host i_host (.sys_clk_i(clk), .strobe_o(strobe), .cd_o(cd), .read_o(rd), .wdata_o(wd));
   lhcd_decoder i_dut (.sys_clk_i(clk), .sys_rst_i(rst), .strobe_i(strobe), .cd_i(cd), .read_i(rd),
      .wdata_i(wd), .rdata_o(rdata), .rvalid_o(rvalid), .column_pointer_o(col), .page_pointer_o(page),
      .advanced_program_regs_o(prog), .front_isolation_clock_o(fiso), .back_isolation_clock_o(biso),
      .lcd_control_field_hi_o(lchi), .lcd_control_field_lo_o(lclo), .ram_address_control_o(rac));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task chk(input string n, input logic [63:0] e, input logic [63:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task cmd(input logic [23:0] b, input int n);
      for (int i = n - 1; i >= 0; i--) i_host.acc(1'b0, 1'b0, b[i*8 +: 8]);
      i_host.idle();
   endtask
   task rdchk(input logic [7:0] e);
      i_host.acc(1'b1, 1'b1, 8'h00);
      i_host.idle();
      chk("rdata", {1'b1, e}, {rvalid, rdata});
   endtask
   task test_done();
      if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #50000;
      num_errors++;
      test_done();
   end
   initial begin
      rst = 1'b1;
      repeat (4) @(posedge clk);
      #5 rst = 1'b0;
      chk("rst_a", {LHCD_COL_RST, LHCD_PAGE_RST, {4{LHCD_PROG_RST}}}, {col, page, prog});
      chk("rst_b", {LHCD_FRONT_ISO_RST, LHCD_BACK_ISO_RST, LHCD_PART_RST, LHCD_MAP_RST, LHCD_RAC_RST, 1'b0},
         {fiso, biso, lchi, lclo, rac, rvalid});
      cmd(24'h051A, 2);
      chk("col", 8'hA5, col);
      cmd(24'h6374, 2);
      chk("page", 7'h43, page);
      // column A5h is off the panel: the write is dropped and the read gives zero
      i_host.acc(1'b1, 1'b0, 8'h5A);
      rdchk(8'h00);
      // the value bytes 0Ch..0Fh would move the column if taken as opcodes
      for (int r = 0; r < 4; r++) begin
         cmd({8'h00, 6'h0C, r[1:0], 6'h03, r[1:0]}, 2);
         chk("prog", {8'hA5, 6'h03, r[1:0]}, {col, prog[r*8 +: 8]});
      end
      cmd(24'h8213F7, 3);
      cmd(24'h82143C, 3);
      chk("iso", 8'h7C, {fiso, biso});
      cmd(24'h868D, 2);
      cmd(24'hC009, 2);
      cmd(24'hC019, 2);
      chk("lc_rac", {2'h2, 4'h9, 3'h5}, {lchi, lclo, rac});
      chk("col_keep", {8'hA5, 7'h43}, {col, page});
      cmd(24'h0211, 2);
      cmd(24'h6370, 2);
      i_host.acc(1'b0, 1'b0, 8'h30);
      i_host.acc(1'b1, 1'b0, 8'hC3);
      cmd(24'h07, 1);
      chk("abort", {8'h17, 8'h0C}, {col, prog[7:0]});
      cmd(24'h02, 1);
      rdchk(8'hC3);
      i_host.acc(1'b0, 1'b1, 8'h00);
      i_host.idle();
      chk("cmd_read", 1'b0, rvalid);
      test_done();
   end
endmodule // lhcd_decoder_tb
`default_nettype wire
